// ---- rtl/adcc_ctrl.v ----
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defines.vh"

module adcc_ctrl (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst_b,
  // AXI4-Lite write
  input  wire [31:0] i_awaddr,
  input  wire        i_awvalid,
  output wire        o_awready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  input  wire        i_wvalid,
  output wire        o_wready,
  output reg  [1:0]  o_bresp,
  output reg         o_bvalid,
  input  wire        i_bready,
  // AXI4-Lite read
  input  wire [31:0] i_araddr,
  input  wire        i_arvalid,
  output wire        o_arready,
  output reg  [31:0] o_rdata,
  output reg  [1:0]  o_rresp,
  output reg         o_rvalid,
  input  wire        i_rready,
  // Converter core
  output reg         o_sample_start,
  output reg  [3:0]  o_channel,
  input  wire        i_conv_done,
  input  wire [9:0]  i_conv_data,
  output reg  [15:0] o_result,
  // Triggers and transfer controller
  input  wire [2:0]  i_timer_out,
  input  wire        i_dtc_active,
  input  wire        i_dtc_block_done,
  // Interrupts
  input  wire        i_irq_ack,
  output wire        o_result_irq_req,
  output wire        o_irq,
  // Analog controls
  output wire        o_converter_power_on,
  output wire        o_reference_generator_on,
  output wire        o_reference_level_select,
  output wire        o_conversion_active
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_CONV = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;

  reg  [15:0] ctl0_q;
  reg  [15:0] ctl0_d;
  reg  [15:0] ctl1_q;
  reg  [15:0] ctl1_d;
  reg  [1:0]  stat_q;
  reg  [1:0]  stat_d;
  reg  [1:0]  mask_q;
  reg         aw_have_q;
  reg  [7:0]  awaddr_q;
  reg         w_have_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg  [1:0]  state_q;
  reg  [15:0] bmask;
  reg  [15:0] wm;
  reg         shi_level;
  reg  [31:0] rd_mux;
  reg         rd_hit;
  reg         wr_hit;
  reg         more;
  reg  [3:0]  chan_next;

  wire        wr_go;
  wire        ar_go;
  wire        trig;
  wire        conversion_enable;
  wire        pwr;
  wire        run_ok;
  wire        msc_eff;
  wire [1:0]  mode;
  wire [3:0]  inch;
  wire        busy;
  wire        res_evt;
  wire        ifg_set;
  wire        seq_done;
  wire [7:0]  araddr;

  assign conversion_enable     = ctl0_q[`ADCC_LOW_ENC];
  assign pwr     = ctl0_q[`ADCC_LOW_PWR];
  assign run_ok  = conversion_enable & pwr;
  assign mode    = ctl1_q[`ADCC_HIGH_SEQ_MSB:`ADCC_HIGH_SEQ_LSB];
  assign inch    = ctl1_q[`ADCC_HIGH_INCH_MSB:`ADCC_HIGH_INCH_LSB];
  assign msc_eff = ctl0_q[`ADCC_LOW_MSC] & (mode != `ADCC_SEQ_SINGLE);
  assign busy    = (state_q != ST_IDLE);
  assign araddr  = i_araddr[7:0];

  // Bus slave: address and data latched separately, any order
  assign o_awready = ~aw_have_q;
  assign o_wready  = ~w_have_q;
  assign wr_go     = aw_have_q & w_have_q & ~o_bvalid;
  assign o_arready = ~o_rvalid;
  assign ar_go     = i_arvalid & ~o_rvalid;

  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      aw_have_q <= 1'b0;
      awaddr_q  <= 8'h00;
      w_have_q  <= 1'b0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `ADCC_RESP_OKAY;
    end else begin
      if (i_awvalid && !aw_have_q) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= i_awaddr[7:0];
      end
      if (i_wvalid && !w_have_q) begin
        w_have_q <= 1'b1;
        wdata_q  <= i_wdata;
        wstrb_q  <= i_wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        o_bvalid  <= 1'b1;
        o_bresp   <= wr_hit ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  always @* begin
    wr_hit = (awaddr_q == `ADCC_OFS_CTL_LOW)  || (awaddr_q == `ADCC_OFS_CTL_HIGH) ||
             (awaddr_q == `ADCC_OFS_RESULT)   || (awaddr_q == `ADCC_OFS_IRQ_STAT) ||
             (awaddr_q == `ADCC_OFS_IRQ_MASK);
    bmask  = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  end

  // Read mux
  always @* begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (araddr)
      `ADCC_OFS_CTL_LOW:  rd_mux = {16'h0000, ctl0_q};
      `ADCC_OFS_CTL_HIGH: rd_mux = {16'h0000, ctl1_q[15:1], busy};
      `ADCC_OFS_RESULT:   rd_mux = {16'h0000, o_result};
      `ADCC_OFS_IRQ_STAT: rd_mux = {30'h0000_0000, stat_q};
      `ADCC_OFS_IRQ_MASK: rd_mux = {30'h0000_0000, mask_q};
      default:            rd_hit = 1'b0;
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0000_0000;
      o_rresp  <= `ADCC_RESP_OKAY;
    end else if (ar_go) begin
      o_rvalid <= 1'b1;
      o_rdata  <= rd_mux;
      o_rresp  <= rd_hit ? `ADCC_RESP_OKAY : `ADCC_RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // Trigger source and edge detection
  always @* begin
    case (ctl1_q[`ADCC_HIGH_SHS_MSB:`ADCC_HIGH_SHS_LSB])
      `ADCC_SHS_SOFT: shi_level = ctl0_q[`ADCC_LOW_SC];
      `ADCC_SHS_TMR1: shi_level = i_timer_out[1];
      `ADCC_SHS_TMR0: shi_level = i_timer_out[0];
      `ADCC_SHS_TMR2: shi_level = i_timer_out[2];
      default:        shi_level = 1'b0;
    endcase
  end

  adcc_edge_det u_edge (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_level (shi_level),
    .i_invert(ctl1_q[`ADCC_HIGH_TRIGGER_INVERT]),
    .o_rise  (trig)
  );

  // Sequencer
  assign res_evt  = (state_q == ST_CONV) & i_conv_done;
  assign seq_done = busy & ~more & (res_evt | (state_q == ST_WAIT & ~conversion_enable) | ~pwr);

  always @* begin
    more      = 1'b0;
    chan_next = o_channel;
    if (state_q == ST_CONV && pwr) begin
      if (mode[0] && o_channel != 4'h0) begin
        more      = 1'b1;
        chan_next = o_channel - 4'h1;
      end else if (mode[1] && conversion_enable) begin
        more      = 1'b1;
        chan_next = inch;
      end
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_q        <= ST_IDLE;
      o_channel      <= 4'h0;
      o_sample_start <= 1'b0;
      o_result       <= `ADCC_RESULT_RST;
    end else begin
      o_sample_start <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (run_ok && trig) begin
            state_q        <= ST_CONV;
            o_channel      <= inch;
            o_sample_start <= 1'b1;
          end
        end
        ST_CONV: begin
          if (!pwr) begin
            state_q <= ST_IDLE;
          end else if (i_conv_done) begin
            o_channel <= chan_next;
            if (!more) begin
              state_q <= ST_IDLE;
            end else if (msc_eff && run_ok) begin
              o_sample_start <= 1'b1;
            end else begin
              state_q <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (!run_ok) begin
            state_q <= ST_IDLE;
          end else if (trig) begin
            state_q        <= ST_CONV;
            o_sample_start <= 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      if (res_evt) begin
        if (ctl1_q[`ADCC_HIGH_DF]) begin
          o_result <= {~i_conv_data[9], i_conv_data[8:0], 6'h00};
        end else begin
          o_result <= {6'h00, i_conv_data};
        end
      end
    end
  end

  // Flag source depends on transfer controller
  assign ifg_set = i_dtc_active ? i_dtc_block_done : res_evt;

  // Control registers
  always @* begin
    ctl0_d                = ctl0_q;
    ctl0_d[`ADCC_LOW_SC]  = 1'b0;
    ctl1_d                = ctl1_q;
    wm                    = 16'h0000;
    if (i_irq_ack) begin
      ctl0_d[`ADCC_LOW_IFG] = 1'b0;
    end
    if (wr_go && awaddr_q == `ADCC_OFS_CTL_LOW) begin
      wm     = conversion_enable ? (bmask & ~`ADCC_LOW_PROT) : bmask;
      ctl0_d = (ctl0_d & ~wm) | (wdata_q[15:0] & wm);
    end
    if (wr_go && awaddr_q == `ADCC_OFS_CTL_HIGH && !conversion_enable) begin
      wm     = bmask & `ADCC_HIGH_WMASK;
      ctl1_d = (ctl1_q & ~wm) | (wdata_q[15:0] & wm);
    end
    if (ifg_set) begin
      ctl0_d[`ADCC_LOW_IFG] = 1'b1;
    end
  end

  // Event status, write one to clear, set wins
  always @* begin
    stat_d = stat_q;
    if (wr_go && awaddr_q == `ADCC_OFS_IRQ_STAT && wstrb_q[0]) begin
      stat_d = stat_q & ~wdata_q[1:0];
    end
    if (res_evt) begin
      stat_d[`ADCC_ST_RESULT] = 1'b1;
    end
    if (seq_done) begin
      stat_d[`ADCC_ST_SEQDONE] = 1'b1;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      ctl0_q <= `ADCC_CTL_LOW_RST;
      ctl1_q <= `ADCC_CTL_HIGH_RST;
      stat_q <= `ADCC_IRQ_RST;
      mask_q <= `ADCC_IRQ_RST;
    end else begin
      ctl0_q <= ctl0_d;
      ctl1_q <= ctl1_d;
      stat_q <= stat_d;
      if (wr_go && awaddr_q == `ADCC_OFS_IRQ_MASK && wstrb_q[0]) begin
        mask_q <= wdata_q[1:0];
      end
    end
  end

  // Outputs
  assign o_result_irq_req = ctl0_q[`ADCC_LOW_IE] & ctl0_q[`ADCC_LOW_IFG];
  assign o_irq            = o_result_irq_req | (|(stat_q & mask_q));
  assign o_converter_power_on     = pwr;
  assign o_reference_generator_on = ctl0_q[`ADCC_LOW_REFERENCE_GENERATOR_ON];
  // Level select meaningless with the reference off
  assign o_reference_level_select = ctl0_q[`ADCC_LOW_REFSEL] & ctl0_q[`ADCC_LOW_REFERENCE_GENERATOR_ON];
  assign o_conversion_active      = busy;

endmodule // adcc_ctrl

`default_nettype wire

// ---- rtl/adcc_defines.vh ----
`ifndef ADCC_DEFINES_VH
`define ADCC_DEFINES_VH

// Byte offsets on the register bus
`define ADCC_OFS_CTL_LOW   8'h00
`define ADCC_OFS_CTL_HIGH  8'h04
`define ADCC_OFS_RESULT    8'h08
`define ADCC_OFS_IRQ_STAT  8'h0C
`define ADCC_OFS_IRQ_MASK  8'h10

// converter_control_low fields
`define ADCC_LOW_MSC       7
`define ADCC_LOW_REFSEL    6
`define ADCC_LOW_REFERENCE_GENERATOR_ON     5
`define ADCC_LOW_PWR       4
`define ADCC_LOW_IE        3
`define ADCC_LOW_IFG       2
`define ADCC_LOW_ENC       1
`define ADCC_LOW_SC        0

// converter_control_high fields
`define ADCC_HIGH_INCH_MSB 15
`define ADCC_HIGH_INCH_LSB 12
`define ADCC_HIGH_SHS_MSB  11
`define ADCC_HIGH_SHS_LSB  10
`define ADCC_HIGH_DF       9
`define ADCC_HIGH_TRIGGER_INVERT     8
`define ADCC_HIGH_SEQ_MSB  2
`define ADCC_HIGH_SEQ_LSB  1
`define ADCC_HIGH_BUSY     0

// Reset values
`define ADCC_CTL_LOW_RST   16'h0000
`define ADCC_CTL_HIGH_RST  16'h0000
`define ADCC_RESULT_RST    16'h0000
`define ADCC_IRQ_RST       2'h0

// Fields frozen while conversion_enable is set
`define ADCC_LOW_PROT      16'hFFF0
`define ADCC_HIGH_PROT     16'hFFFE
`define ADCC_HIGH_WMASK    16'hFFFE

// Sequence modes
`define ADCC_SEQ_SINGLE    2'h0
`define ADCC_SEQ_CHANNELS  2'h1
`define ADCC_SEQ_REP_ONE   2'h2
`define ADCC_SEQ_REP_SEQ   2'h3

// Trigger sources
`define ADCC_SHS_SOFT      2'h0
`define ADCC_SHS_TMR1      2'h1
`define ADCC_SHS_TMR0      2'h2
`define ADCC_SHS_TMR2      2'h3

// Status bits
`define ADCC_ST_RESULT     0
`define ADCC_ST_SEQDONE    1

// Bus responses
`define ADCC_RESP_OKAY     2'h0
`define ADCC_RESP_SLVERR   2'h2

`endif

// ---- rtl/adcc_edge_det.v ----
`timescale 1ns/1ps
`default_nettype none

module adcc_edge_det (
  // Clock and reset
  input  wire i_clk,
  input  wire i_rst_b,
  // Level in
  input  wire i_level,
  input  wire i_invert,
  // Edge out
  output wire o_rise
);

  wire cur;
  reg  prev_q;

  assign cur    = i_level ^ i_invert;
  assign o_rise = cur & ~prev_q;

  // Reset high so an inverted idle level is no edge
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= cur;
    end
  end

endmodule // adcc_edge_det

`default_nettype wire

// ---- testbench/adcc_ctrl_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl_checker (
  // Watched ports
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic        i_conv_done,
  input wire logic [9:0]  i_conv_data,
  input wire logic        i_irq_ack,
  input wire logic        i_dtc_block_done,
  input wire logic        i_awvalid,
  input wire logic        o_sample_start,
  input wire logic [15:0] o_result,
  input wire logic        o_result_irq_req,
  input wire logic        o_irq,
  input wire logic        o_converter_power_on,
  input wire logic        o_reference_generator_on,
  input wire logic        o_reference_level_select,
  input wire logic        o_conversion_active
);
  logic [9:0] data_q;
  always @(posedge i_clk) data_q <= i_conv_data;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  start_pulse_a: assert property (o_sample_start |=> !o_sample_start)
    else $error("start pulse too long");
  start_busy_a: assert property (o_sample_start |-> o_conversion_active)
    else $error("start without busy");
  start_power_a: assert property (o_sample_start |-> o_converter_power_on)
    else $error("start while powered down");
  power_idle_a: assert property (!o_converter_power_on [*2] |-> !o_conversion_active)
    else $error("busy while powered down");
  req_irq_a: assert property (o_result_irq_req |-> o_irq)
    else $error("request not on irq line");
  ref_level_a: assert property (o_reference_level_select |-> o_reference_generator_on)
    else $error("level select without reference");
  ack_clear_a: assert property (i_irq_ack && !i_conv_done && !i_dtc_block_done
    && !i_awvalid |=> !o_result_irq_req) else $error("flag kept after ack");
  result_fmt_a: assert property (i_conv_done |=> o_result == {6'h00, data_q} ||
    o_result == {~data_q[9], data_q[8:0], 6'h00}) else $error("result format wrong");
endmodule // adcc_ctrl_checker
bind adcc_ctrl adcc_ctrl_checker u_chk (.i_clk, .i_rst_b, .i_conv_done, .i_conv_data,
  .i_irq_ack, .i_dtc_block_done, .i_awvalid, .o_sample_start, .o_result,
  .o_result_irq_req, .o_irq, .o_converter_power_on, .o_reference_generator_on,
  .o_reference_level_select, .o_conversion_active);
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        i_clk, i_rst_b, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [31:0] i_awaddr, i_wdata, i_araddr, o_rdata;
  logic [3:0]  i_wstrb, o_channel;
  logic [1:0]  o_bresp, o_rresp, r;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_sample_start;
  logic        i_conv_done, i_dtc_active, i_dtc_block_done, i_irq_ack, o_irq;
  logic [9:0]  i_conv_data, d;
  logic [15:0] o_result;
  logic [2:0]  i_timer_out;
  logic        o_result_irq_req, o_converter_power_on, o_conversion_active;
  logic        o_reference_generator_on, o_reference_level_select;
  int          failures, comparisons, cycles, starts, n;
  logic [15:0] exp_q[$];

  adcc_ctrl u_dut (.i_clk, .i_rst_b, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
    .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_sample_start,
    .o_channel, .i_conv_done, .i_conv_data, .o_result, .i_timer_out, .i_dtc_active,
    .i_dtc_block_done, .i_irq_ack, .o_result_irq_req, .o_irq, .o_converter_power_on,
    .o_reference_generator_on, .o_reference_level_select, .o_conversion_active);

  initial i_clk = 1'h0;
  always #12.5 i_clk = ~i_clk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard; whole run needs a few hundred cycles
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (o_sample_start) starts <= starts + 1;
    if (cycles == 20000) begin
      failures++;
      report_and_stop;
    end
  end

  always @(posedge i_clk)
    if (o_rvalid && i_rready) chk(o_rdata, {16'h0000, exp_q.pop_front()});

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    i_awaddr <= {24'h000000, a};
    i_wdata <= {16'h0000, v};
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    do begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 1'h0;
      if (o_wready) i_wvalid <= 1'h0;
    end while (!o_bvalid);
    r = o_bresp;
    i_bready <= 1'h0;
    @(posedge i_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    i_araddr <= {24'h000000, a};
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    do @(posedge i_clk); while (!o_arready);
    i_arvalid <= 1'h0;
    exp_q.push_back(e);
    do @(posedge i_clk); while (!o_rvalid);
    i_rready <= 1'h0;
    @(posedge i_clk);
  endtask

  // No trailing edge: a chained start follows done at once
  task automatic conv(input logic [3:0] ch);
    d = 10'($urandom);
    // A start launched at the caller's last edge is still visible now
    while (!o_sample_start) @(posedge i_clk);
    chk(o_channel, ch);
    repeat (3) @(posedge i_clk);
    i_conv_done <= 1'h1;
    i_conv_data <= d;
    @(posedge i_clk);
    i_conv_done <= 1'h0;
    i_conv_data <= ~d;
  endtask

  task automatic quiet(input logic b);
    n = starts;
    repeat (10) @(posedge i_clk);
    chk(starts, n);
    chk(o_conversion_active, b);
  endtask

  initial begin
    {i_rst_b, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h00;
    {i_awaddr, i_wdata, i_araddr} = 96'h0;
    {i_conv_done, i_dtc_active, i_dtc_block_done, i_irq_ack} = 4'h0;
    i_conv_data = 10'h000;
    i_timer_out = 3'h0;
    i_wstrb = 4'hF;
    void'($urandom(32'h2CF1));
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1'h1;
    @(posedge i_clk);
    rd(8'h00, 16'h0000);
    rd(8'h04, 16'h0000);
    wr(8'h20, 16'h1234);
    chk(r, 2'h2);
    rd(8'h20, 16'h0000);
    chk(o_rresp, 2'h2);
    $display("Test reset done");
    wr(8'h00, 16'h001B);
    conv(4'h0);
    rd(8'h00, 16'h001E);
    rd(8'h08, {6'h00, d});
    chk(o_result_irq_req, 1'h1);
    chk(o_converter_power_on, 1'h1);
    wr(8'h00, 16'h001A);
    chk(o_result_irq_req, 1'h0);
    chk(o_irq, 1'h0);
    wr(8'h10, 16'h0001);
    chk(o_irq, 1'h1);
    wr(8'h0C, 16'h0001);
    chk(o_irq, 1'h0);
    $display("Test start done");
    i_dtc_active <= 1'h1;
    wr(8'h00, 16'h001B);
    conv(4'h0);
    rd(8'h00, 16'h001A);
    i_dtc_block_done <= 1'h1;
    @(posedge i_clk);
    i_dtc_block_done <= 1'h0;
    i_dtc_active <= 1'h0;
    @(posedge i_clk);
    chk(o_result_irq_req, 1'h1);
    i_irq_ack <= 1'h1;
    @(posedge i_clk);
    i_irq_ack <= 1'h0;
    @(posedge i_clk);
    chk(o_result_irq_req, 1'h0);
    $display("Test flag done");
    wr(8'h04, 16'h0200);
    rd(8'h04, 16'h0000);
    wr(8'h00, 16'h0010);
    i_wstrb <= 4'h2;
    wr(8'h04, 16'h0201);
    i_wstrb <= 4'hF;
    rd(8'h04, 16'h0200);
    wr(8'h00, 16'h0013);
    conv(4'h0);
    rd(8'h08, {~d[9], d[8:0], 6'h00});
    wr(8'h00, 16'h0010);
    wr(8'h04, 16'h2000);
    wr(8'h00, 16'h0093);
    conv(4'h2);
    quiet(1'h0);
    $display("Test format done");
    wr(8'h00, 16'h0010);
    wr(8'h04, 16'h2002);
    wr(8'h00, 16'h0093);
    for (int c = 2; c >= 0; c--) conv(4'(c));
    quiet(1'h0);
    rd(8'h0C, 16'h0003);
    wr(8'h00, 16'h0010);
    wr(8'h04, 16'h1002);
    wr(8'h00, 16'h0013);
    conv(4'h1);
    quiet(1'h1);
    wr(8'h00, 16'h0013);
    conv(4'h0);
    $display("Test sequence done");
    for (int s = 1; s < 4; s++) begin
      wr(8'h00, 16'h0010);
      wr(8'h04, 16'(s * 16'h0402 + 16'h0100));
      wr(8'h00, 16'h0012);
      i_timer_out <= 3'h7;
      quiet(1'h0);
      i_timer_out <= 3'h0;
      conv(4'h0);
      wr(8'h00, 16'h0010);
      quiet(1'h0);
    end
    $display("Test trigger done");
    wr(8'h00, 16'h0060);
    chk(o_reference_generator_on, 1'h1);
    chk(o_reference_level_select, 1'h1);
    wr(8'h00, 16'h0040);
    chk(o_reference_level_select, 1'h0);
    chk(o_reference_generator_on, 1'h0);
    chk(o_converter_power_on, 1'h0);
    wr(8'h04, 16'h0000);
    wr(8'h00, 16'h0003);
    quiet(1'h0);
    $display("Test power done");
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
